// *** cta_asserts.sv ***
// Port-level checks of the counter array.
`timescale 1ns/1ps
module cta_asserts (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  gpio_out,
    input wire logic [7:0]  gpio_oe,
    input wire logic [7:0]  p1_out,
    input wire logic [7:0]  p1_oe,
    input wire logic        irq
);
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite && pready;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup; psel && !penable && ce; endsequence
    sequence s_mask_off; wr_acc && ce && paddr == 12'h388 && pwdata[5:0] == 6'h00 ##1 ce; endsequence
    property p_answer; s_setup |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no ready after setup");
    property p_pulse; pready && ce |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_quiet; !pready |-> prdata == 32'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("read data outside access");
    property p_resv; pready && !pwrite && paddr == 12'h364 |-> prdata[31:8] == 24'h0 && prdata[5:3] == 3'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved mode bits not zero");
    property p_gpio; $past(ce) && $past(rst_n) |-> ((p1_out ^ $past(gpio_out)) & 8'h03) == 8'h00 && ((p1_oe ^ $past(gpio_oe)) & 8'h03) == 8'h00; endproperty
    a_gpio: assert property (p_gpio) else $error("free pin not passed through");
    property p_fall; $fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2); endproperty
    a_fall: assert property (p_fall) else $error("interrupt dropped without a write");
    property p_mask; s_mask_off |=> !irq; endproperty
    a_mask: assert property (p_mask) else $error("interrupt with all masked");
endmodule : cta_asserts

// *** cta_defs.svh ***
// Register indices, field positions, reset values and counts of the counter array.
`ifndef CTA_DEFS_SVH
`define CTA_DEFS_SVH

`define CTA_NMOD        5
`define CTA_NSTAT       6
`define CTA_OVF_BIT     5
`define CTA_WDT_MOD     4
`define CTA_ECI_PIN     3'h2
`define CTA_PIN_BASE    3'h3

`define CTA_IDX_ARRAY_COUNTER_MODE    8'hd9
`define CTA_IDX_CNT     8'he0
`define CTA_IDX_STAT    8'he1
`define CTA_IDX_MASK    8'he2
`define CTA_IDX_MODE0   8'he8
`define CTA_IDX_CMP0    8'hf0
`define CTA_ADDR_HI_ZERO 2'h0

`define CTA_BIT_IDLE    7
`define CTA_BIT_MODULE4_WATCHDOG_ON    6
`define CTA_BIT_SEL_HI  2
`define CTA_BIT_SEL_LO  1
`define CTA_BIT_OVF_EN  0

`define CTA_SEL_DIV6    2'h0
`define CTA_SEL_DIV2    2'h1
`define CTA_SEL_T0      2'h2
`define CTA_SEL_ECI     2'h3
`define CTA_DIV6_LAST   3'h5

`define CTA_RST_CNT     16'h0000
`define CTA_RST_CMP     16'h0000
`define CTA_RST_STAT    6'h00
`define CTA_RST_MASK    6'h00
`define CTA_RST_PRESC   3'h0
`define CTA_CNT_MAX     16'hffff

`endif

// *** cta_module.sv ***
// One compare/capture module of the counter array.
`timescale 1ns/1ps
`include "cta_defs.svh"

module cta_module (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              run,
    input  wire logic              tick,
    input  wire logic [15:0]       cnt,
    input  wire logic [15:0]       cmp,
    input  wire cta_pkg::cta_mode_t mode,
    input  wire logic              pin_in,
    input  wire logic              wdt_en,
    output logic                   evt,
    output logic                   cap,
    output logic                   pin_out,
    output logic                   wdt_hit
);

    cta_pkg::cta_mod_state_t s_q;
    cta_pkg::cta_mod_state_t s_d;
    logic                    rise;
    logic                    fall;
    logic                    match;

    assign rise  = pin_in & ~s_q.pin_prev;
    assign fall  = ~pin_in & s_q.pin_prev;
    assign match = run & tick & (cnt == cmp);

    always_comb begin
        s_d          = s_q;
        s_d.pin_prev = pin_in;
        cap          = 1'b0;
        evt          = 1'b0;
        wdt_hit      = 1'b0;
        case (mode)
            cta_pkg::CTA_CAP_RISE: cap = run & rise;
            cta_pkg::CTA_CAP_FALL: cap = run & fall;
            cta_pkg::CTA_CAP_BOTH: cap = run & (rise | fall);
            cta_pkg::CTA_SW_TIMER: begin
                evt     = match;
                wdt_hit = wdt_en & match;
            end
            cta_pkg::CTA_HS_OUT: begin
                evt     = match;
                wdt_hit = wdt_en & match;
                if (match) begin
                    s_d.pin_out = ~s_q.pin_out;
                end
            end
            cta_pkg::CTA_PWM: begin
                // Only the low byte compares, so the period is 256 counter ticks.
                if (run & tick) begin
                    s_d.pin_out = (cnt[7:0] >= cmp[7:0]);
                end
            end
            default: s_d.pin_out = s_q.pin_out;
        endcase
        if (cap) begin
            evt = 1'b1;
        end
    end

    assign pin_out = s_q.pin_out;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

endmodule : cta_module

// *** cta_pins.sv ***
// Port pins and timer 0 overflow as seen from outside the counter array.
`timescale 1ns/1ps
module cta_pins (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] ext_lvl,
    input  wire logic [7:0] p1_out,
    input  wire logic [7:0] p1_oe,
    output logic            t0_ovf,
    output logic      [7:0] p1_in
);
    logic [2:0] tick_q;
    always_ff @(posedge core_clk) begin
        tick_q <= rst_n ? tick_q + 3'h1 : 3'h0;
    end
    // Overflow every fourth cycle, so any 24-cycle window holds exactly six.
    assign t0_ovf = tick_q[1:0] == 2'h3;
    // A driven pin shows the array's level; pin 2 carries a free-running count source.
    always_comb begin
        p1_in = (p1_oe & p1_out) | (~p1_oe & ext_lvl);
        if (!p1_oe[2]) begin
            p1_in[2] = tick_q[2];
        end
    end
endmodule : cta_pins

// *** cta_pkg.sv ***
// Types shared by the counter array time base and its compare/capture modules.
package cta_pkg;

    typedef enum logic [2:0] {
        CTA_OFF      = 3'h0,
        CTA_CAP_RISE = 3'h1,
        CTA_CAP_FALL = 3'h2,
        CTA_CAP_BOTH = 3'h3,
        CTA_SW_TIMER = 3'h4,
        CTA_HS_OUT   = 3'h5,
        CTA_PWM      = 3'h6
    } cta_mode_t;

    typedef struct packed {
        logic pin_prev;
        logic pin_out;
    } cta_mod_state_t;

    typedef struct packed {
        logic [2:0]            presc;
        logic                  eci_prev;
        logic [15:0]           cnt;
        logic                  idle_stop;
        logic                  module4_watchdog_on;
        logic [1:0]            src_sel;
        logic                  ovf_en;
        cta_mode_t [4:0]       mode;
        logic [4:0][15:0]      cmp;
        logic [5:0]            status;
        logic [5:0]            mask;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        logic                  irq;
        logic                  wdt_rst;
        logic [7:0]            p1_out;
        logic [7:0]            p1_oe;
    } cta_state_t;

endpackage : cta_pkg

// *** cta_top.sv ***
// Counter array time base with register access over APB and five compare/capture modules.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "cta_defs.svh"

module cta_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_idle,
    input  wire logic        t0_ovf,
    input  wire logic [7:0]  p1_in,
    input  wire logic [7:0]  gpio_out,
    input  wire logic [7:0]  gpio_oe,
    output logic      [7:0]  p1_out,
    output logic      [7:0]  p1_oe,
    output logic             irq,
    output logic             wdt_rst
);

    cta_pkg::cta_state_t s_q;
    cta_pkg::cta_state_t s_d;
    logic [4:0]          m_evt;
    logic [4:0]          m_cap;
    logic [4:0]          m_pin;
    logic [4:0]          m_wdt;
    logic                run;
    logic                tick;
    logic [7:0]          idx;
    logic                addr_ok;
    logic                wr_acc;
    logic [7:0]          array_counter_mode_rd;

    // Gating in idle holds the prescaler too, so the first tick after idle keeps its phase.
    assign run = ~(cpu_idle & s_q.idle_stop);

    always_comb begin
        case (s_q.src_sel)
            `CTA_SEL_DIV6: tick = (s_q.presc == `CTA_DIV6_LAST);
            `CTA_SEL_DIV2: tick = s_q.presc[0];
            `CTA_SEL_T0:   tick = t0_ovf;
            `CTA_SEL_ECI:  tick = s_q.eci_prev & ~p1_in[`CTA_ECI_PIN];
            default:       tick = 1'b0;
        endcase
    end

    generate
        for (genvar g = 0; g < `CTA_NMOD; g++) begin : g_mod
            cta_module u_mod (
                .core_clk (core_clk),
                .rst_n    (rst_n),
                .ce       (ce),
                .run      (run),
                .tick     (tick),
                .cnt      (s_q.cnt),
                .cmp      (s_q.cmp[g]),
                .mode     (s_q.mode[g]),
                .pin_in   (p1_in[g + `CTA_PIN_BASE]),
                .wdt_en   ((g == `CTA_WDT_MOD) ? s_q.module4_watchdog_on : 1'b0),
                .evt      (m_evt[g]),
                .cap      (m_cap[g]),
                .pin_out  (m_pin[g]),
                .wdt_hit  (m_wdt[g])
            );
        end
    endgenerate

    assign idx     = paddr[9:2];
    assign addr_ok = (paddr[11:10] == `CTA_ADDR_HI_ZERO) &&
                     ((idx == `CTA_IDX_ARRAY_COUNTER_MODE) || (idx == `CTA_IDX_CNT) || (idx == `CTA_IDX_STAT) ||
                      (idx == `CTA_IDX_MASK) ||
                      ((idx >= `CTA_IDX_MODE0) && (idx < `CTA_IDX_MODE0 + 8'(`CTA_NMOD))) ||
                      ((idx >= `CTA_IDX_CMP0) && (idx < `CTA_IDX_CMP0 + 8'(`CTA_NMOD))));
    assign wr_acc  = psel & penable & s_q.pready & pwrite & addr_ok;

    // Reserved bits 5..3 read as zero.
    always_comb begin
        array_counter_mode_rd                  = 8'h00;
        array_counter_mode_rd[`CTA_BIT_IDLE]   = s_q.idle_stop;
        array_counter_mode_rd[`CTA_BIT_MODULE4_WATCHDOG_ON]   = s_q.module4_watchdog_on;
        array_counter_mode_rd[`CTA_BIT_SEL_HI] = s_q.src_sel[1];
        array_counter_mode_rd[`CTA_BIT_SEL_LO] = s_q.src_sel[0];
        array_counter_mode_rd[`CTA_BIT_OVF_EN] = s_q.ovf_en;
    end

    always_comb begin
        logic       ovf;
        logic [5:0] set;
        logic [5:0] clr;
        ovf = 1'b0;
        set = 6'h00;
        clr = 6'h00;
        s_d = s_q;

        // Time base.
        if (run) begin
            // Divide by 2 toggles bit 0 and clears bits 2..1, so the first tick comes within two cycles of a source change.
            if (s_q.src_sel == `CTA_SEL_DIV2) begin
                s_d.presc = {2'h0, ~s_q.presc[0]};
            end else if (s_q.presc == `CTA_DIV6_LAST) begin
                s_d.presc = `CTA_RST_PRESC;
            end else begin
                s_d.presc = s_q.presc + 3'h1;
            end
            if (tick) begin
                s_d.cnt = s_q.cnt + 16'h0001;
                ovf     = (s_q.cnt == `CTA_CNT_MAX);
            end
        end
        s_d.eci_prev = p1_in[`CTA_ECI_PIN];

        // A capture loads the counter value into the module's compare register.
        for (int i = 0; i < `CTA_NMOD; i++) begin
            if (m_cap[i]) begin
                s_d.cmp[i] = s_q.cnt;
            end
        end

        // APB: no wait state, the answer is registered during the setup cycle.
        s_d.pready  = psel & ~penable;
        s_d.pslverr = psel & ~penable & ~addr_ok;
        s_d.prdata  = 32'h0000_0000;
        if (psel & ~penable & addr_ok) begin
            if (idx == `CTA_IDX_ARRAY_COUNTER_MODE) begin
                s_d.prdata[7:0] = array_counter_mode_rd;
            end
            if (idx == `CTA_IDX_CNT) begin
                s_d.prdata[15:0] = s_q.cnt;
            end
            if (idx == `CTA_IDX_STAT) begin
                s_d.prdata[5:0] = s_q.status;
            end
            if (idx == `CTA_IDX_MASK) begin
                s_d.prdata[5:0] = s_q.mask;
            end
            for (int i = 0; i < `CTA_NMOD; i++) begin
                if (idx == `CTA_IDX_MODE0 + 8'(i)) begin
                    s_d.prdata[2:0] = s_q.mode[i];
                end
                if (idx == `CTA_IDX_CMP0 + 8'(i)) begin
                    s_d.prdata[15:0] = s_q.cmp[i];
                end
            end
        end

        if (wr_acc) begin
            if (idx == `CTA_IDX_ARRAY_COUNTER_MODE) begin
                s_d.idle_stop = pwdata[`CTA_BIT_IDLE];
                s_d.module4_watchdog_on      = pwdata[`CTA_BIT_MODULE4_WATCHDOG_ON];
                s_d.src_sel   = {pwdata[`CTA_BIT_SEL_HI], pwdata[`CTA_BIT_SEL_LO]};
                s_d.ovf_en    = pwdata[`CTA_BIT_OVF_EN];
            end
            if (idx == `CTA_IDX_CNT) begin
                s_d.cnt = pwdata[15:0];
            end
            if (idx == `CTA_IDX_STAT) begin
                clr = pwdata[5:0];
            end
            if (idx == `CTA_IDX_MASK) begin
                s_d.mask = pwdata[5:0];
            end
            for (int i = 0; i < `CTA_NMOD; i++) begin
                if (idx == `CTA_IDX_MODE0 + 8'(i)) begin
                    s_d.mode[i] = cta_pkg::cta_mode_t'(pwdata[2:0]);
                end
                if (idx == `CTA_IDX_CMP0 + 8'(i)) begin
                    s_d.cmp[i] = pwdata[15:0];
                end
            end
        end

        // Sticky status: a new event in the clearing cycle survives the clear.
        set                   = {1'b0, m_evt};
        set[`CTA_OVF_BIT]     = ovf & s_q.ovf_en;
        s_d.status            = (s_q.status & ~clr) | set;
        s_d.irq               = |(s_d.status & s_q.mask);
        s_d.wdt_rst           = m_wdt[`CTA_WDT_MOD];

        // Port 1 steering: pins not claimed by the array pass the general-purpose drive.
        s_d.p1_out = gpio_out;
        s_d.p1_oe  = gpio_oe;
        if (s_q.src_sel == `CTA_SEL_ECI) begin
            s_d.p1_oe[`CTA_ECI_PIN] = 1'b0;
        end
        for (int i = 0; i < `CTA_NMOD; i++) begin
            case (s_q.mode[i])
                cta_pkg::CTA_HS_OUT, cta_pkg::CTA_PWM: begin
                    s_d.p1_out[i + `CTA_PIN_BASE] = m_pin[i];
                    s_d.p1_oe[i + `CTA_PIN_BASE]  = 1'b1;
                end
                cta_pkg::CTA_CAP_RISE, cta_pkg::CTA_CAP_FALL, cta_pkg::CTA_CAP_BOTH: begin
                    s_d.p1_oe[i + `CTA_PIN_BASE] = 1'b0;
                end
                default: begin
                    s_d.p1_oe[i + `CTA_PIN_BASE] = gpio_oe[i + `CTA_PIN_BASE];
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q        <= '0;
            s_q.cnt    <= `CTA_RST_CNT;
            s_q.status <= `CTA_RST_STAT;
            s_q.mask   <= `CTA_RST_MASK;
            s_q.presc  <= `CTA_RST_PRESC;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign prdata  = s_q.prdata;
    assign pready  = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign irq     = s_q.irq;
    assign wdt_rst = s_q.wdt_rst;
    assign p1_out  = s_q.p1_out;
    assign p1_oe   = s_q.p1_oe;

endmodule : cta_top

// *** tb.sv ***
// Self-checking bench of the counter array top level.
`timescale 1ns/1ps
module tb;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        ce       = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0;
    logic        cpu_idle = 1'b0;
    logic [7:0]  gpio_out = 8'h02;
    logic [7:0]  gpio_oe  = 8'h03;
    logic [7:0]  ext      = 8'h00;
    logic [31:0] prdata;
    logic        pready, pslverr, t0_ovf, irq, wdt_rst;
    logic [7:0]  p1_in, p1_out, p1_oe;
    int          err_total   = 0;
    int          checks_done = 0;
    int          wdt_cnt     = 0;
    logic [7:0]  md [6] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h82, 8'h02};
    logic [31:0] ex [6] = '{32'h4, 32'hc, 32'h6, 32'h3, 32'h0, 32'hc};

    always #2.5 core_clk = ~core_clk;

    cta_top cta_top_inst (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_idle(cpu_idle), .t0_ovf(t0_ovf), .p1_in(p1_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .p1_out(p1_out), .p1_oe(p1_oe), .irq(irq), .wdt_rst(wdt_rst));
    cta_pins cta_pins_inst (.core_clk(core_clk), .rst_n(rst_n), .ext_lvl(ext), .p1_out(p1_out),
        .p1_oe(p1_oe), .t0_ovf(t0_ovf), .p1_in(p1_in));

    always @(posedge core_clk) begin
        if (wdt_rst === 1'b1) begin
            wdt_cnt <= wdt_cnt + 1;
        end
    end

    task automatic test_done;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rdc

    // Two counter reads whose setup edges lie 24 cycles apart, so every source gives a whole count.
    task automatic delta(input logic [31:0] exp);
        logic [31:0] a, b;
        logic        e;
        apb(1'b0, 12'h380, 32'h0, a, e);
        repeat (21) @(posedge core_clk);
        apb(1'b0, 12'h380, 32'h0, b, e);
        chk((b - a) & 32'hffff, exp);
    endtask : delta

    initial begin
        #20000;
        err_total++;
        test_done();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        rdc(12'h364, 32'h0);
        rdc(12'h380, 32'h0);
        wr(12'h364, 32'hff);
        rdc(12'h364, 32'hc7);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            cpu_idle <= i > 3;
            wr(12'h364, {24'h0, md[i]});
            delta(ex[i]);
        end
        wr(12'h388, 32'h20);
        for (int k = 0; k < 2; k++) begin
            wr(12'h364, k ? 32'h03 : 32'h02);
            wr(12'h380, 32'hfff8);
            repeat (30) @(posedge core_clk);
            chk({31'h0, irq}, 32'(k));
            rdc(12'h384, k ? 32'h20 : 32'h0);
        end
        wr(12'h388, 32'h0);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        wr(12'h384, 32'h20);
        rdc(12'h384, 32'h0);
        for (int n = 0; n < 5; n++) begin
            wr(12'h3a0 + 12'(4 * n), 32'(1 + n % 3));
        end
        ext <= 8'hf8;
        repeat (4) @(posedge core_clk);
        rdc(12'h384, 32'h0d);
        chk({27'h0, p1_oe[7:3]}, 32'h0);
        ext <= 8'h00;
        repeat (4) @(posedge core_clk);
        rdc(12'h384, 32'h1f);
        wr(12'h384, 32'h1f);
        wr(12'h3d0, 32'h8000);
        wr(12'h3b0, 32'h5);
        for (int k = 0; k < 2; k++) begin
            wr(12'h364, k ? 32'h42 : 32'h02);
            wr(12'h380, 32'h7ff0);
            repeat (50) @(posedge core_clk);
            chk(wdt_cnt, k);
            chk({30'h0, p1_oe[7], p1_out[7]}, k ? 32'h2 : 32'h3);
            rdc(12'h384, 32'h10);
            wr(12'h384, 32'h10);
        end
        wr(12'h3c0, 32'h1000);
        wr(12'h3a0, 32'h4);
        wr(12'h380, 32'h0ff8);
        repeat (30) @(posedge core_clk);
        rdc(12'h384, 32'h01);
        chk(wdt_cnt, 32'h1);
        wr(12'h384, 32'h01);
        wr(12'h3cc, 32'h0);
        wr(12'h3ac, 32'h6);
        repeat (4) @(posedge core_clk);
        chk({30'h0, p1_oe[6], p1_out[6]}, 32'h3);
        gpio_out <= 8'h01;
        repeat (2) @(posedge core_clk);
        chk({28'h0, p1_oe[1:0], p1_out[1:0]}, 32'hd);
        test_done();
    end
endmodule : tb

bind cta_top cta_asserts cta_asserts_inst (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .p1_out(p1_out), .p1_oe(p1_oe), .irq(irq));
